// ### src/pllsp_defs.svh
// Numeric constants of the serial-programmed PLL digital section
`ifndef PLLSP_DEFS_SVH
`define PLLSP_DEFS_SVH
`define PLLSP_WORD_W 24
`define PLLSP_REF_RATIO_W 14
`define PLLSP_FB_RATIO_W 13
`define PLLSP_REF_RATIO_MAX 14'h3FFF
`define PLLSP_FB_RATIO_MAX 13'h1FFF
`define PLLSP_REF_RST 24'h000004
`define PLLSP_FB_RST 24'h000101
`define PLLSP_FUNC_RST 24'h000082
`define PLLSP_CLK_PS 5000
`define PLLSP_LOCK_NS 15
`define PLLSP_UNLOCK_NS 25
`define PLLSP_LOCK_CYC (`PLLSP_LOCK_NS * 1000 / `PLLSP_CLK_PS)
`define PLLSP_UNLOCK_CYC (`PLLSP_UNLOCK_NS * 1000 / `PLLSP_CLK_PS)
`define PLLSP_LOCK_NEED_LO 3
`define PLLSP_LOCK_NEED_HI 5
`define PLLSP_ABL_00_PS 2900
`define PLLSP_ABL_01_PS 1300
`define PLLSP_ABL_10_PS 6000
`define PLLSP_ABL_11_PS 2900
`define PLLSP_CYC_UP(ps) (((ps) + `PLLSP_CLK_PS - 1) / `PLLSP_CLK_PS)
`define PLLSP_ERR_MAX 8'hFF
`define PLLSP_IN_SCLK 0
`define PLLSP_IN_SDATA 1
`define PLLSP_IN_LOAD 2
`define PLLSP_IN_CE 3
`define PLLSP_IN_REF 4
`define PLLSP_IN_FB 5
`define PLLSP_IN_N 6
`endif

// ### src/pllsp_pkg.sv
// Types of the serial-programmed PLL digital section
package pllsp_pkg;
   typedef enum logic [1:0] {
      LSEL_REF = 2'h0, LSEL_FB = 2'h1, LSEL_FUNC = 2'h2, LSEL_INIT = 2'h3
   } pllsp_lsel_e;
   typedef enum logic [2:0] {
      OSEL_OFF = 3'h0, OSEL_DLOCK = 3'h1, OSEL_FBDIV = 3'h2, OSEL_HIGH = 3'h3,
      OSEL_REFDIV = 3'h4, OSEL_ALOCK = 3'h5, OSEL_SDOUT = 3'h6, OSEL_LOW = 3'h7
   } pllsp_osel_e;
   typedef enum logic [1:0] {
      PFD_IDLE = 2'h0, PFD_WAIT = 2'h1, PFD_ABL = 2'h2
   } pllsp_pfd_e;
   typedef struct packed {
      logic [2:0] unused; logic lock_precision_sel; logic [1:0] test_mode_bits;
      logic antibacklash_sel_high; logic antibacklash_sel_low;
      logic [13:0] reference_ratio_bits; logic [1:0] latch_sel;
   } pllsp_ref_s;
   typedef struct packed {
      logic [1:0] unused_hi; logic pump_gain_sel; logic [12:0] feedback_ratio_bits;
      logic [5:0] unused_lo; logic [1:0] latch_sel;
   } pllsp_fb_s;
   typedef struct packed {
      logic [1:0] unused; logic powerdown_bit_b; logic [2:0] pump_current_set2;
      logic [2:0] pump_current_bits; logic [3:0] timeout_count_bits;
      logic fastlock_mode_bit; logic fastlock_enable_bit; logic pump_tristate_bit;
      logic phase_polarity_bit; logic [2:0] outsel; logic powerdown_bit_a;
      logic counter_reset_bit; logic [1:0] latch_sel;
   } pllsp_func_s;
endpackage : pllsp_pkg

// ### src/pllsp_top.sv
// Serial-programmed PLL digital section: shift register, latches, dividers, PFD, lock detect, mux
`timescale 1ns/1ps
`include "pllsp_defs.svh"
// Function
// - Feedback divider divides by any programmed ratio 1 to 8191, one pulse per N.
// - Reference divider is 14-bit, ratio 1 to 16383, feeding the phase detector.
// - Host gives one bit per serial clock; captured on each rising serial clock edge.
// - Rising load strobe copies the shift register into the latch chosen by DB1, DB0.
// - Select 00 reference, 01 feedback, 10 function, 11 initialization latch.
// - Reference word: DB2-15 ratio, DB16-17 antibacklash, DB18-19 test, DB20 precision.
// - Feedback word: DB8-20 ratio, DB21 pump gain; other bits ignored.
// - Function word fields: counter reset, power-downs, mux, polarity, tristate, fastlock, timeout, currents.
// - Phase detector compares divider outputs and emits selectable-width antibacklash pulse.
// - Observe output presents the signal picked by the three mux select bits.
// - Digital lock high after three consecutive cycles under 15 ns when precision is 0.
// - With precision 1, five consecutive cycles under 15 ns are needed.
// - Lock stays high until a later cycle shows error above 25 ns.
// - Analog lock detect in lock stays high with only narrow low pulses.
// - Chip enable low powers down and tristates pump; high powers up per power-down bits.
module pllsp_top (
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic SCLK_I,
   input wire logic SDATA_I,
   input wire logic LOAD_STROBE_I,
   input wire logic CHIP_EN_I,
   input wire logic REF_IN_I,
   input wire logic FB_IN_I,
   output logic PUMP_UP_O,
   output logic PUMP_DN_O,
   output logic PUMP_OE_O,
   output logic [2:0] PUMP_CURRENT_O,
   output logic OBS_O,
   output logic OBS_OE_O,
   output logic LOCK_O,
   output logic POWERED_O
);
   // Antibacklash width in cycles, rounded up since it is a least time
   function automatic logic [1:0] abl_cycles(input logic [1:0] sel);
      logic [1:0] cyc;
      cyc = 2'h1;
      case (sel)
         2'h0: cyc = 2'(`PLLSP_CYC_UP(`PLLSP_ABL_00_PS));
         2'h1: cyc = 2'(`PLLSP_CYC_UP(`PLLSP_ABL_01_PS));
         2'h2: cyc = 2'(`PLLSP_CYC_UP(`PLLSP_ABL_10_PS));
         default: cyc = 2'(`PLLSP_CYC_UP(`PLLSP_ABL_11_PS));
      endcase
      return cyc;
   endfunction : abl_cycles

   // Divider wrap test; a ratio of zero behaves as one
   function automatic logic div_wrap(input logic [13:0] cnt, input logic [13:0] ratio);
      return (ratio == 14'h0000) || (cnt >= ratio - 14'h0001);
   endfunction : div_wrap

   logic [`PLLSP_IN_N-1:0] meta_ff;
   logic [`PLLSP_IN_N-1:0] sync_ff;
   logic [`PLLSP_IN_N-1:0] prev_ff;
   logic [`PLLSP_WORD_W-1:0] shift_ff;
   pllsp_pkg::pllsp_ref_s ref_ff;
   pllsp_pkg::pllsp_fb_s fb_ff;
   pllsp_pkg::pllsp_func_s func_ff;
   logic init_clr_ff;
   logic [13:0] div_cnt_ff [2];
   logic [1:0] div_pulse_ff;
   pllsp_pkg::pllsp_pfd_e pfd_ff;
   pllsp_pkg::pllsp_pfd_e nxt_pfd;
   logic up_ff;
   logic dn_ff;
   logic nxt_up;
   logic nxt_dn;
   logic [7:0] err_ff;
   logic [7:0] nxt_err;
   logic [1:0] abl_ff;
   logic [1:0] nxt_abl;
   logic done_ff;
   logic [7:0] done_err_ff;
   logic [2:0] good_ff;
   logic lock_ff;
   logic obs_ff;
   logic obs_oe_ff;
   logic nxt_obs;
   logic nxt_obs_oe;

   // Two-flop synchronisers; prev_ff only ever looks at the second stage
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= {FB_IN_I, REF_IN_I, CHIP_EN_I, LOAD_STROBE_I, SDATA_I, SCLK_I};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // Edge detects and decoded controls
   wire [`PLLSP_IN_N-1:0] rise = sync_ff & ~prev_ff;
   wire sclk_rise = rise[`PLLSP_IN_SCLK];
   wire load_rise = rise[`PLLSP_IN_LOAD];
   wire chip_en = sync_ff[`PLLSP_IN_CE];
   wire [1:0] latch_sel = shift_ff[1:0];
   // power gating by chip enable and both power-down bits
   wire powered = chip_en & ~func_ff.powerdown_bit_a & ~func_ff.powerdown_bit_b;
   // counter reset bit and power-down hold the dividers
   wire div_hold = func_ff.counter_reset_bit | ~powered | init_clr_ff;
   // reference word antibacklash and precision fields
   wire [1:0] abl_len = abl_cycles({ref_ff.antibacklash_sel_high, ref_ff.antibacklash_sel_low});
   wire [2:0] lock_need = ref_ff.lock_precision_sel ? 3'(`PLLSP_LOCK_NEED_HI) : 3'(`PLLSP_LOCK_NEED_LO);
   wire err_good = done_err_ff < 8'(`PLLSP_LOCK_CYC);
   wire err_bad = done_err_ff > 8'(`PLLSP_UNLOCK_CYC);
   wire ref_p = div_pulse_ff[0];
   wire fb_p = div_pulse_ff[1];

   // serial capture, MSB first so select bits end lowest
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         shift_ff <= '0;
      end else if (sclk_rise) begin
         shift_ff <= {shift_ff[`PLLSP_WORD_W-2:0], sync_ff[`PLLSP_IN_SDATA]};
      end
   end

   // load strobe transfers the word; select decode
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ref_ff <= `PLLSP_REF_RST;
         fb_ff <= `PLLSP_FB_RST;
         func_ff <= `PLLSP_FUNC_RST;
         init_clr_ff <= 1'b0;
      end else begin
         init_clr_ff <= load_rise && (latch_sel == pllsp_pkg::LSEL_INIT);
         if (load_rise) begin
            case (latch_sel)
               pllsp_pkg::LSEL_REF: ref_ff <= shift_ff;
               pllsp_pkg::LSEL_FB: fb_ff <= shift_ff;
               // Initialization shares the function layout and also clears the dividers
               default: func_ff <= shift_ff;
            endcase
         end
      end
   end

   // two binary dividers counting input rising edges
   for (genvar g = 0; g < 2; g++) begin : g_div
      wire [13:0] ratio = (g == 0) ? ref_ff.reference_ratio_bits : {1'b0, fb_ff.feedback_ratio_bits};
      wire in_edge = rise[(g == 0) ? `PLLSP_IN_REF : `PLLSP_IN_FB];
      wire wrap = div_wrap(div_cnt_ff[g], ratio);
      always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
         if (!RST_N_I) begin
            div_cnt_ff[g] <= '0;
            div_pulse_ff[g] <= 1'b0;
         end else if (div_hold) begin
            div_cnt_ff[g] <= '0;
            div_pulse_ff[g] <= 1'b0;
         end else begin
            div_pulse_ff[g] <= in_edge & wrap;
            if (in_edge) begin
               div_cnt_ff[g] <= wrap ? 14'h0000 : div_cnt_ff[g] + 14'h0001;
            end
         end
      end
   end

   // phase detector: measure gap, then hold both pumps for the antibacklash width
   always_comb begin
      nxt_pfd = pfd_ff;
      nxt_up = up_ff;
      nxt_dn = dn_ff;
      nxt_err = err_ff;
      nxt_abl = abl_ff;
      case (pfd_ff)
         pllsp_pkg::PFD_IDLE: begin
            nxt_err = 8'h00;
            nxt_up = ref_p;
            nxt_dn = fb_p;
            nxt_abl = abl_len;
            if (ref_p && fb_p) begin
               nxt_pfd = pllsp_pkg::PFD_ABL;
            end else if (ref_p || fb_p) begin
               nxt_pfd = pllsp_pkg::PFD_WAIT;
            end
         end
         pllsp_pkg::PFD_WAIT: begin
            if (err_ff != `PLLSP_ERR_MAX) begin
               nxt_err = err_ff + 8'h01;
            end
            if ((up_ff && fb_p) || (dn_ff && ref_p)) begin
               nxt_up = 1'b1;
               nxt_dn = 1'b1;
               nxt_pfd = pllsp_pkg::PFD_ABL;
            end
         end
         pllsp_pkg::PFD_ABL: begin
            nxt_abl = abl_ff - 2'h1;
            if (abl_ff <= 2'h1) begin
               nxt_up = 1'b0;
               nxt_dn = 1'b0;
               nxt_pfd = pllsp_pkg::PFD_IDLE;
            end
         end
         default: begin
            nxt_up = 1'b0;
            nxt_dn = 1'b0;
            nxt_pfd = pllsp_pkg::PFD_IDLE;
         end
      endcase
      if (div_hold) begin
         nxt_pfd = pllsp_pkg::PFD_IDLE;
         nxt_up = 1'b0;
         nxt_dn = 1'b0;
      end
   end

   // Phase detector state; done_ff marks each finished comparison with its error
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pfd_ff <= pllsp_pkg::PFD_IDLE;
         up_ff <= 1'b0;
         dn_ff <= 1'b0;
         err_ff <= '0;
         abl_ff <= '0;
         done_ff <= 1'b0;
         done_err_ff <= '0;
      end else begin
         pfd_ff <= nxt_pfd;
         up_ff <= nxt_up;
         dn_ff <= nxt_dn;
         err_ff <= nxt_err;
         abl_ff <= nxt_abl;
         done_ff <= (nxt_pfd == pllsp_pkg::PFD_ABL) && (pfd_ff != pllsp_pkg::PFD_ABL);
         done_err_ff <= nxt_err;
      end
   end

   // digital lock with hysteresis between 15 ns and 25 ns
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         good_ff <= '0;
         lock_ff <= 1'b0;
      end else if (div_hold) begin
         good_ff <= '0;
         lock_ff <= 1'b0;
      end else if (done_ff) begin
         if (err_good) begin
            good_ff <= (good_ff < lock_need) ? good_ff + 3'h1 : good_ff;
            if (good_ff + 3'h1 >= lock_need) begin
               lock_ff <= 1'b1;
            end
         end else begin
            good_ff <= '0;
            if (err_bad) begin
               lock_ff <= 1'b0;
            end
         end
      end
   end

   // observe mux; analog detect pulls low only during pump activity
   always_comb begin
      nxt_obs = 1'b0;
      nxt_obs_oe = 1'b1;
      case (pllsp_pkg::pllsp_osel_e'(func_ff.outsel))
         pllsp_pkg::OSEL_OFF: nxt_obs_oe = 1'b0;
         pllsp_pkg::OSEL_DLOCK: nxt_obs = lock_ff;
         pllsp_pkg::OSEL_FBDIV: nxt_obs = fb_p;
         pllsp_pkg::OSEL_HIGH: nxt_obs = 1'b1;
         pllsp_pkg::OSEL_REFDIV: nxt_obs = ref_p;
         pllsp_pkg::OSEL_ALOCK: nxt_obs_oe = up_ff ^ dn_ff;
         pllsp_pkg::OSEL_SDOUT: nxt_obs = shift_ff[`PLLSP_WORD_W-1];
         default: nxt_obs = 1'b0;
      endcase
   end

   // Registered observe pin, a pipeline stage so it never glitches
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         obs_ff <= 1'b0;
         obs_oe_ff <= 1'b0;
      end else begin
         obs_ff <= nxt_obs;
         obs_oe_ff <= nxt_obs_oe;
      end
   end

   // pump drive: polarity swaps the pumps, tristate bit or power-down floats them
   assign PUMP_OE_O = powered & ~func_ff.pump_tristate_bit;
   assign PUMP_UP_O = PUMP_OE_O & (func_ff.phase_polarity_bit ? up_ff : dn_ff);
   assign PUMP_DN_O = PUMP_OE_O & (func_ff.phase_polarity_bit ? dn_ff : up_ff);
   // pump gain select picks the second current setting
   assign PUMP_CURRENT_O = fb_ff.pump_gain_sel ? func_ff.pump_current_set2 : func_ff.pump_current_bits;
   assign OBS_O = obs_ff;
   assign OBS_OE_O = obs_oe_ff;
   assign LOCK_O = lock_ff;
   assign POWERED_O = powered;

   // Checks on the logic above
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   chk_shift_capture: assert property (sclk_rise |=> shift_ff[0] == $past(sync_ff[`PLLSP_IN_SDATA])) else $error("serial bit lost");
   chk_shift_order: assert property (sclk_rise |=> shift_ff[23:1] == $past(shift_ff[22:0])) else $error("shift order wrong");
   chk_ref_load: assert property (load_rise && latch_sel == 2'h0 |=> ref_ff == $past(shift_ff)) else $error("ref word not loaded");
   chk_fb_load: assert property (load_rise && latch_sel == 2'h1 |=> fb_ff == $past(shift_ff) && $stable(ref_ff)) else $error("fb load");
   chk_ref_wrap: assert property (div_pulse_ff[0] |-> div_cnt_ff[0] == 14'h0000) else $error("ref divider wrap wrong");
   chk_fb_step: assert property (!div_hold && rise[5] && !g_div[1].wrap ##1 !div_hold |-> div_cnt_ff[1] == $past(div_cnt_ff[1]) + 14'h0001) else $error("fb count");
   chk_abl_both: assert property (done_ff |-> up_ff && dn_ff) else $error("antibacklash pulse missing");
   chk_lock_three: assert property (done_ff && err_good && !ref_ff.lock_precision_sel && good_ff == 3'h2 && !div_hold |=> lock_ff) else $error("lock late");
   chk_lock_five: assert property (done_ff && ref_ff.lock_precision_sel && good_ff == 3'h2 && !lock_ff |=> !lock_ff) else $error("lock early");
   chk_unlock_err: assert property (done_ff && err_bad |=> !lock_ff) else $error("lock held after large error");
   chk_mux_lock: assert property (func_ff.outsel == 3'h1 && $stable(func_ff) |=> OBS_O == $past(lock_ff) && OBS_OE_O) else $error("mux");
   chk_alock_pull: assert property (func_ff.outsel == 3'h5 && $stable(func_ff) && !(up_ff ^ dn_ff) |=> !OBS_OE_O) else $error("alock");
   chk_ce_off: assert property (!chip_en |-> !PUMP_OE_O && !PUMP_UP_O && !PUMP_DN_O) else $error("pump driven in power-down");
endmodule : pllsp_top

// ### sim/pllsp_host.sv
// Host-side model that shifts programming words over the three-wire link
`timescale 1ns/1ps
module pllsp_host (
   output logic sclk_o,
   output logic sdata_o,
   output logic load_o
);
   // Link idles with clock and strobe low between words
   initial begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      load_o = 1'b0;
   end
   // One word per call; gap_ns stretches the low phase to act as a slow host
   task automatic send_word(input logic [23:0] word, input int gap_ns);
      for (int i = 23; i >= 0; i--) begin
         sdata_o = word[i];
         #(32 + gap_ns);
         // one bit per rising clock, data held across it
         sclk_o = 1'b1;
         #32;
         sclk_o = 1'b0;
      end
      #32;
      // strobe rises only after the last bit
      load_o = 1'b1;
      #64;
      load_o = 1'b0;
      // Data is a don't-care between words, so drive the inverse of the last bit
      sdata_o = ~word[0];
   endtask : send_word
endmodule : pllsp_host

// ### sim/tb_top.sv
// Self-checking bench for the serial-programmed PLL digital section
`timescale 1ns/1ps
module tb_top;
   typedef struct {string name; int sel; logic [15:0] exp;} pllsp_note_s;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic chip_en = 1'b0;
   logic ref_in = 1'b0;
   logic fb_in = 1'b0;
   logic sclk, sdata, load_strobe, pump_up, pump_dn, pump_oe, obs, obs_oe, lock, powered;
   logic [2:0] pump_cur;
   logic [15:0] outs;
   pllsp_note_s notes[$];
   event note_ev;
   int miscompares = 0;
   int n_compared = 0;
   int rise_cnt = 0;
   logic obs_prev = 1'b0;
   // Code 6 shows the shift register MSB, which is DB23 of the last word and always one here
   logic [2:0] codes [4] = '{3'h3, 3'h7, 3'h0, 3'h6};
   logic obs_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   logic oe_exp [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

   // System clock, 5 ns period
   always #2.5 clk_sys = ~clk_sys;

   pllsp_top i_dut (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .SCLK_I(sclk), .SDATA_I(sdata),
      .LOAD_STROBE_I(load_strobe), .CHIP_EN_I(chip_en), .REF_IN_I(ref_in), .FB_IN_I(fb_in),
      .PUMP_UP_O(pump_up), .PUMP_DN_O(pump_dn), .PUMP_OE_O(pump_oe), .PUMP_CURRENT_O(pump_cur),
      .OBS_O(obs), .OBS_OE_O(obs_oe), .LOCK_O(lock), .POWERED_O(powered));
   pllsp_host i_host (.sclk_o(sclk), .sdata_o(sdata), .load_o(load_strobe));

   // Observed outputs packed so one selector picks the field under test
   assign outs = {6'h0, pump_dn, pump_up, lock, powered, pump_oe, obs, obs_oe, pump_cur};

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic note_exp(input string name, input int sel, input logic [15:0] exp);
      pllsp_note_s n;
      n.name = name;
      n.sel = sel;
      n.exp = exp;
      notes.push_back(n);
      -> note_ev;
   endtask : note_exp

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   // Counts observe-pin pulses on the falling edge, away from output updates
   always @(negedge clk_sys) begin
      if (obs === 1'b1 && obs_prev === 1'b0) begin
         rise_cnt++;
      end
      obs_prev = obs;
   end

   // Checker process: drains all queued notes, oldest first, whenever one is posted
   initial begin : monitor
      pllsp_note_s n;
      logic [15:0] seen;
      forever begin
         @(note_ev);
         while (notes.size() != 0) begin
            n = notes.pop_front();
            seen = (n.sel == 10) ? 16'(rise_cnt) : ((outs >> n.sel) & ((n.sel == 0) ? 16'h0007 : 16'h0001));
            check(n.name, seen, n.exp);
         end
      end
   end

   // Watchdog sized well above the expected run of about 50 us
   initial begin : watchdog
      #300000;
      miscompares++;
      print_verdict();
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : tick

   task automatic send(input logic [23:0] w);
      i_host.send_word(w, 20 * ($urandom % 3));
      tick(8);
   endtask : send

   function automatic logic [23:0] ref_word(input int r, input logic prec, input logic [1:0] abl);
      return {3'h7, prec, 2'h0, abl, r[13:0], 2'h0};
   endfunction : ref_word

   // Ignored bits are set to ones so a decoder that reads them shows up
   function automatic logic [23:0] fb_word(input int n, input logic gain);
      return {2'h3, gain, n[12:0], 6'h3F, 2'h1};
   endfunction : fb_word

   function automatic logic [23:0] fn_word(input logic [2:0] mux, input logic pd_a, input logic pd_b);
      return {2'h3, pd_b, 3'h2, 3'h5, 4'h0, 3'h0, 1'b1, mux, pd_a, 1'b0, 2'h2};
   endfunction : fn_word

   // Loads ratios, then an initialization word that restarts the dividers
   task automatic prog(input int r, input int n, input logic prec, input logic [2:0] mux);
      send(ref_word(r, prec, 2'h2));
      send(fb_word(n, 1'b0));
      send(fn_word(mux, 1'b0, 1'b0) | 24'h000003);
   endtask : prog

   task automatic pulses(input logic on_ref, input int k);
      repeat (k) begin
         @(posedge clk_sys);
         if (on_ref) ref_in <= 1'b1;
         else fb_in <= 1'b1;
         repeat (4) @(posedge clk_sys);
         ref_in <= 1'b0;
         fb_in <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      tick(6);
   endtask : pulses

   // One comparison with fb lagging ref by d system cycles
   task automatic pd_cycle(input int d);
      @(posedge clk_sys);
      ref_in <= 1'b1;
      if (d == 0) fb_in <= 1'b1;
      if (d > 0) begin
         tick(d - 1);
         if (d > 6) begin
            note_exp("pump_up_lead", 8, 16'h0001);
            note_exp("pump_dn_lead", 9, 16'h0000);
         end
         @(posedge clk_sys);
         fb_in <= 1'b1;
      end
      repeat (8) @(posedge clk_sys);
      ref_in <= 1'b0;
      fb_in <= 1'b0;
      repeat (12) @(posedge clk_sys);
      tick(2);
   endtask : pd_cycle

   initial begin : main
      int r;
      int n;
      r = $urandom(32'h6FB4);
      tick(3);
      note_exp("lock_in_reset", 7, 16'h0000);
      note_exp("powered_in_reset", 6, 16'h0000);
      repeat (13) @(posedge clk_sys);
      rst_n <= 1'b1;
      chip_en <= 1'b1;
      tick(8);
      note_exp("powered_after_reset", 6, 16'h0001);
      $display("Test reset done");
      r = 1 + ($urandom % 7);
      n = 1 + ($urandom % 7);
      prog(r, n, 1'b0, 3'h4);
      rise_cnt = 0;
      pulses(1'b1, 3 * r);
      note_exp("ref_div_pulses", 10, 16'h0003);
      send(fn_word(3'h2, 1'b0, 1'b0));
      rise_cnt = 0;
      pulses(1'b0, 3 * n);
      note_exp("fb_div_pulses", 10, 16'h0003);
      $display("Test dividers done");
      for (int i = 0; i < 4; i++) begin
         send(fn_word(codes[i], 1'b0, 1'b0));
         note_exp("obs_level", 4, 16'(obs_exp[i]));
         note_exp("obs_enable", 3, 16'(oe_exp[i]));
      end
      note_exp("current_set1", 0, 16'h0005);
      send(fb_word(n, 1'b1));
      note_exp("current_set2", 0, 16'h0002);
      $display("Test mux and current done");
      send(fn_word(3'h0, 1'b1, 1'b0));
      note_exp("powered_pd_a", 6, 16'h0000);
      note_exp("pump_oe_pd_a", 5, 16'h0000);
      send(fn_word(3'h0, 1'b0, 1'b1));
      note_exp("powered_pd_b", 6, 16'h0000);
      // Tristate bit DB8 floats the pump while the part stays powered
      send(fn_word(3'h0, 1'b0, 1'b0) | 24'h000100);
      note_exp("pump_oe_tristate", 5, 16'h0000);
      note_exp("powered_tristate", 6, 16'h0001);
      send(fn_word(3'h0, 1'b0, 1'b0));
      note_exp("powered_up", 6, 16'h0001);
      @(posedge clk_sys);
      chip_en <= 1'b0;
      tick(6);
      note_exp("powered_chip_off", 6, 16'h0000);
      note_exp("pump_oe_chip_off", 5, 16'h0000);
      @(posedge clk_sys);
      chip_en <= 1'b1;
      $display("Test power down done");
      for (int prec = 0; prec < 2; prec++) begin
         prog(1, 1, prec[0], 3'h5);
         repeat (prec ? 4 : 2) pd_cycle(2);
         note_exp("lock_one_short", 7, 16'h0000);
         pd_cycle(2);
         note_exp("lock_set", 7, 16'h0001);
         note_exp("analog_lock_released", 3, 16'h0000);
         pd_cycle(4);
         note_exp("lock_hysteresis", 7, 16'h0001);
         pd_cycle(7);
         note_exp("lock_lost", 7, 16'h0000);
      end
      prog(1, 1, 1'b0, 3'h1);
      repeat (5) pd_cycle(3);
      note_exp("lock_at_15ns", 7, 16'h0000);
      note_exp("obs_dlock_low", 4, 16'h0000);
      // Three good comparisons set lock, which the observe pin must follow
      repeat (3) pd_cycle(2);
      note_exp("obs_dlock_high", 4, 16'h0001);
      $display("Test lock detect done");
      tick(2);
      print_verdict();
   end
endmodule : tb_top
